// ### cbt_pkg.sv
package cbt_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 50;
    localparam int RX_ON_MAX_NS       = 500;
    localparam int RX_OFF_HIGH_NS     = 250;
    localparam int RX_REARM_NS        = 500;
    localparam int TX_QUAL_PULSE_NS   = 25;
    localparam int TX_OFF_IDLE_NS     = 150;
    localparam int COL_ONSET_MAX_NS   = 700;
    localparam int COL_HIGH_IDLE_NS   = 170;
    localparam int HB_DELAY_NS        = 1000;
    localparam int HB_BURST_NS        = 1000;
    localparam int JAB_LIMIT_MS       = 30;
    localparam int UNJAB_NS           = 450;
    localparam int DISC_LIMIT_MS      = 800;
    localparam int OSC_HALF_NS        = 50;

    // Least times round up, longest round down, never under one cycle
    localparam int RX_OFF_CYC   = (RX_OFF_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_REARM_CYC = (RX_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TX_QUAL_CYC  = (TX_QUAL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TX_OFF_CYC   = (TX_OFF_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_IDLE_CYC = (COL_HIGH_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HB_DELAY_CYC = HB_DELAY_NS / CLK_PERIOD_NS;
    localparam int HB_BURST_CYC = HB_BURST_NS / CLK_PERIOD_NS;
    localparam int UNJAB_CYC    = (UNJAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_HALF_CYC = OSC_HALF_NS / CLK_PERIOD_NS;
    localparam int JAB_CYC      = JAB_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DISC_CYC     = DISC_LIMIT_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Counter widths
    // ------------------------------------------------------------
    localparam int SHORT_W = 8;
    localparam int LONG_W  = 25;
    localparam int DATA_W  = 1;
    localparam int FIFO_D  = 32;

    // ------------------------------------------------------------
    // Squelch state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SQ_IDLE  = 4'h1,
        SQ_ZERO  = 4'h2,
        SQ_ON    = 4'h4,
        SQ_REARM = 4'h8
    } cbt_sq_t;
endpackage

// ### cbt_fifo.sv
`timescale 1ns/1ns
module cbt_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } cbt_fifo_st_t;

    cbt_fifo_st_t          st_ff;
    cbt_fifo_st_t          nxt_st;
    logic [WIDTH-1:0]      mem_ff [DEPTH];
    logic                  push;
    logic                  pop;

    assign in_ready_out  = (st_ff.cnt != DEPTH[AW:0]);
    assign out_valid_out = (st_ff.cnt != '0);
    assign out_data_out  = mem_ff[st_ff.rd];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage carries no reset
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem_ff[st_ff.wr] <= in_data_in;
        end
    end
endmodule // cbt_fifo

// ### cbt_ctrl.sv
`timescale 1ns/1ns
// Summary of operation
// - Receive output opens after level above squelch and a 01 start, a low then a rising edge on sense.
// - Receive turn-on completes within five bit times at normal levels.
// - Receive shuts off after 250 ns high, rearms only after 0.5 us.
// - Transmit opens only on a 01 start with long enough negative pulses.
// - Transmit closes after 150 ns without negative excursions.
// - Collisions detected in receive mode, local station involved or not.
// - Collision driver enabled while averaged level beyond collision threshold.
// - Collision shown as 10 MHz oscillation within 700 ns of onset.
// - Collision signal starts low and ends with over 170 ns high idle.
// - After each transmission, 1 us heartbeat burst about 1 us later.
// - Heartbeat suppressed when heartbeat permission input is held off.
// - Jabber inhibits transmitter after 30 ms of continuous transmission.
// - While jabbed, collision driven to packet end plus unjab time, then release.
// - Cable disconnected puts station receive and collision outputs in high impedance; carrier output enable is not gated by it.
// - Receive driver idles powered down, wakes on receive signal or collision driver activity; collision driver wakes on collision, heartbeat or jabber.
// - Heartbeat active while permission input is held high.
// - Transmit permission low disables cable transmitter and holds transmit squelch idle.
// - Carrier output sinks low while carrier present, high impedance otherwise.
// - Disconnect recognised only after sense beyond disable level for 800 ms.
module cbt_ctrl
    import cbt_pkg::*;
#(
    parameter int JAB_CYCLES  = cbt_pkg::JAB_CYC,
    parameter int DISC_CYCLES = cbt_pkg::DISC_CYC
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic coax_sense_in,
    input  wire logic coax_squelch_in,
    input  wire logic coax_collide_in,
    input  wire logic coax_open_in,
    input  wire logic station_tx_in,
    input  wire logic station_tx_neg_in,
    input  wire logic heartbeat_allow,
    input  wire logic coax_tx_permit,
    output logic      station_rx_out,
    output logic      station_rx_oe_out,
    output logic      collision_pair_out,
    output logic      collision_pair_oe_out,
    output logic      coax_drive_out,
    output logic      carrier_present_out,
    output logic      carrier_present_oe_out,
    output logic      jabbed_out,
    output logic      cable_lost_out
);
    import cbt_pkg::*;

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0]         s1;
        logic [9:0]         s2;
        cbt_sq_t            rx_sq;
        logic [SHORT_W-1:0] rx_cnt;
        logic               rx_prev;
        cbt_sq_t            tx_sq;
        logic [SHORT_W-1:0] tx_cnt;
        logic [SHORT_W-1:0] neg_cnt;
        logic               col_act;
        logic [SHORT_W-1:0] col_idle;
        logic [SHORT_W-1:0] osc_cnt;
        logic               osc_ph;
        logic               hb_wait;
        logic               hb_burst;
        logic [SHORT_W-1:0] hb_cnt;
        logic [LONG_W-1:0]  jab_cnt;
        logic               jab;
        logic               jab_tail;
        logic [SHORT_W-1:0] unjab_cnt;
        logic [LONG_W-1:0]  disc_cnt;
        logic               lost;
        logic               rx_d;
        logic               cd_d;
    } cbt_st_t;

    cbt_st_t st_ff;
    cbt_st_t nxt_st;

    // Synchronised pins: bit order sense,squelch,collide,open,tx,neg,hb,permit
    logic [9:0] raw;
    logic       sense;
    logic       sq_lvl;
    logic       col_lvl;
    logic       open_lvl;
    logic       tx_in;
    logic       tx_neg;
    logic       hb_ok;
    logic       tx_ok;
    logic       f_ready;
    logic       f_valid;
    logic       f_data;
    logic       tx_on;
    logic       col_req;
    logic       drivers_up;

    assign raw = {2'b00, coax_tx_permit, heartbeat_allow, station_tx_neg_in,
                  station_tx_in, coax_open_in, coax_collide_in, coax_squelch_in,
                  coax_sense_in};
    assign sense    = st_ff.s2[0];
    assign sq_lvl   = st_ff.s2[1];
    assign col_lvl  = st_ff.s2[2];
    assign open_lvl = st_ff.s2[3];
    assign tx_in    = st_ff.s2[4];
    assign tx_neg   = st_ff.s2[5];
    assign hb_ok    = st_ff.s2[6];
    assign tx_ok    = st_ff.s2[7];
    assign tx_on    = (st_ff.tx_sq == SQ_ON);

    // ------------------------------------------------------------
    // Transmit data path
    // ------------------------------------------------------------
    // Buffer, drained every cycle, delays transmit data one cycle while transmit squelch is on
    cbt_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_D)
    ) u_tx_fifo (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (tx_on),
        .in_ready_out  (f_ready),
        .in_data_in    (tx_in),
        .out_valid_out (f_valid),
        .out_ready_in  (1'b1),
        .out_data_out  (f_data)
    );

    assign coax_drive_out = f_valid && f_data && tx_ok && !jabbed_out && f_ready;

    assign col_req = col_lvl || st_ff.jab || st_ff.jab_tail || st_ff.hb_burst;

    assign drivers_up = st_ff.rx_sq == SQ_ON || st_ff.col_act;

    always_comb begin
        nxt_st = st_ff;
        // Two-stage synchroniser, second stage only is read
        nxt_st.s1      = raw;
        nxt_st.s2      = st_ff.s1;
        nxt_st.rx_prev = sense;

        // --------------------------------------------------------
        // Receive squelch
        // --------------------------------------------------------
        case (st_ff.rx_sq)
            SQ_IDLE: begin
                nxt_st.rx_cnt = '0;
                if (sq_lvl && !sense) begin
                    nxt_st.rx_sq = SQ_ZERO;
                end
            end
            SQ_ZERO: begin
                if (!sq_lvl) begin
                    nxt_st.rx_sq = SQ_IDLE;
                end else if (sense && !st_ff.rx_prev) begin
                    nxt_st.rx_sq  = SQ_ON;
                    nxt_st.rx_cnt = '0;
                end
            end
            SQ_ON: begin
                nxt_st.rx_cnt = sense ? st_ff.rx_cnt + 1'b1 : '0;
                if (sense && st_ff.rx_cnt >= SHORT_W'(RX_OFF_CYC - 1)) begin
                    nxt_st.rx_sq  = SQ_REARM;
                    nxt_st.rx_cnt = '0;
                end
            end
            SQ_REARM: begin
                nxt_st.rx_cnt = st_ff.rx_cnt + 1'b1;
                if (st_ff.rx_cnt >= SHORT_W'(RX_REARM_CYC - 1)) begin
                    nxt_st.rx_sq = SQ_IDLE;
                end
            end
            default: nxt_st.rx_sq = SQ_IDLE;
        endcase

        // --------------------------------------------------------
        // Transmit squelch
        // --------------------------------------------------------
        nxt_st.neg_cnt = tx_neg ? st_ff.neg_cnt + 1'b1 : '0;
        case (st_ff.tx_sq)
            SQ_IDLE: begin
                nxt_st.tx_cnt = '0;
                if (tx_ok && !tx_neg && st_ff.neg_cnt >= SHORT_W'(TX_QUAL_CYC)) begin
                    nxt_st.tx_sq = tx_in ? SQ_ON : SQ_ZERO;
                end
            end
            SQ_ZERO: begin
                if (tx_in) begin
                    nxt_st.tx_sq = SQ_ON;
                end else if (tx_neg) begin
                    nxt_st.tx_sq = SQ_IDLE;
                end
            end
            SQ_ON: begin
                nxt_st.tx_cnt = tx_neg ? '0 : st_ff.tx_cnt + 1'b1;
                if (!tx_neg && st_ff.tx_cnt >= SHORT_W'(TX_OFF_CYC)) begin
                    nxt_st.tx_sq = SQ_IDLE;
                end
            end
            default: nxt_st.tx_sq = SQ_IDLE;
        endcase
        if (!tx_ok) begin
            nxt_st.tx_sq = SQ_IDLE;
        end

        // --------------------------------------------------------
        // Heartbeat
        // --------------------------------------------------------
        // delay then burst
        if (tx_on && nxt_st.tx_sq == SQ_IDLE && hb_ok) begin
            nxt_st.hb_wait = 1'b1;
            nxt_st.hb_cnt  = '0;
        end else if (st_ff.hb_wait) begin
            nxt_st.hb_cnt = st_ff.hb_cnt + 1'b1;
            if (st_ff.hb_cnt >= SHORT_W'(HB_DELAY_CYC - 1)) begin
                nxt_st.hb_wait  = 1'b0;
                nxt_st.hb_burst = 1'b1;
                nxt_st.hb_cnt   = '0;
            end
        end else if (st_ff.hb_burst) begin
            nxt_st.hb_cnt = st_ff.hb_cnt + 1'b1;
            if (st_ff.hb_cnt >= SHORT_W'(HB_BURST_CYC - 1)) begin
                nxt_st.hb_burst = 1'b0;
            end
        end
        if (!hb_ok) begin
            nxt_st.hb_wait  = 1'b0;
            nxt_st.hb_burst = 1'b0;
        end

        // --------------------------------------------------------
        // Jabber
        // --------------------------------------------------------
        // long counters sized
        if (tx_on && !st_ff.jab) begin
            nxt_st.jab_cnt = st_ff.jab_cnt + 1'b1;
            if (st_ff.jab_cnt >= LONG_W'(JAB_CYCLES - 1)) begin
                nxt_st.jab = 1'b1;
            end
        end else if (!tx_on) begin
            nxt_st.jab_cnt = '0;
        end
        if (st_ff.jab && !tx_on) begin
            nxt_st.jab       = 1'b0;
            nxt_st.jab_tail  = 1'b1;
            nxt_st.unjab_cnt = '0;
        end else if (st_ff.jab_tail) begin
            nxt_st.unjab_cnt = st_ff.unjab_cnt + 1'b1;
            if (st_ff.unjab_cnt >= SHORT_W'(UNJAB_CYC - 1)) begin
                nxt_st.jab_tail = 1'b0;
            end
        end

        // --------------------------------------------------------
        // Collision oscillator
        // --------------------------------------------------------
        // comparator enables driver
        if (col_req && !st_ff.lost) begin
            nxt_st.col_idle = '0;
            if (!st_ff.col_act) begin
                nxt_st.col_act = 1'b1;
                nxt_st.osc_ph  = 1'b0;
                nxt_st.osc_cnt = '0;
            end else if (st_ff.osc_cnt >= SHORT_W'(OSC_HALF_CYC - 1)) begin
                nxt_st.osc_ph  = !st_ff.osc_ph;
                nxt_st.osc_cnt = '0;
            end else begin
                nxt_st.osc_cnt = st_ff.osc_cnt + 1'b1;
            end
        end else if (st_ff.col_act) begin
            // high hold, one extra for output register; lost ends at once
            nxt_st.osc_ph   = 1'b1;
            nxt_st.col_idle = st_ff.col_idle + 1'b1;
            if (st_ff.lost || st_ff.col_idle >= SHORT_W'(COL_IDLE_CYC + 1)) begin
                nxt_st.col_act = 1'b0;
            end
        end

        // --------------------------------------------------------
        // Cable disconnect
        // --------------------------------------------------------
        // sustained open only
        if (open_lvl) begin
            if (st_ff.disc_cnt >= LONG_W'(DISC_CYCLES - 1)) begin
                nxt_st.lost = 1'b1;
            end else begin
                nxt_st.disc_cnt = st_ff.disc_cnt + 1'b1;
            end
        end else begin
            nxt_st.disc_cnt = '0;
            nxt_st.lost     = 1'b0;
        end

        nxt_st.rx_d = (st_ff.rx_sq == SQ_ON) && sense;
        nxt_st.cd_d = st_ff.col_act && st_ff.osc_ph;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff       <= '0;
            st_ff.rx_sq <= SQ_IDLE;
            st_ff.tx_sq <= SQ_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign station_rx_out        = st_ff.rx_d;
    assign station_rx_oe_out     = drivers_up && !st_ff.lost;
    assign collision_pair_out    = st_ff.cd_d;
    assign collision_pair_oe_out = st_ff.col_act && !st_ff.lost;
    assign carrier_present_out   = 1'b0;
    assign carrier_present_oe_out = (st_ff.rx_sq == SQ_ON);
    assign jabbed_out            = st_ff.jab || st_ff.jab_tail;
    assign cable_lost_out        = st_ff.lost;
endmodule // cbt_ctrl

// ### cbt_station_model.sv
`timescale 1ns/1ns
module cbt_station_model #(
    parameter int DLY = 5
) (
    input  wire logic       ref_clk_in,
    input  wire logic       go_in,
    input  wire logic       good_start_in,
    input  wire logic [7:0] len_in,
    output logic            tx_out,
    output logic            tx_neg_out
);
    initial begin
        tx_out = 1'b0;
        tx_neg_out = 1'b0;
    end
    // Idle data toggles so a stale level never passes for a frame
    // Go taken at the edge, clear of the bench's delayed writes
    always @(posedge ref_clk_in) begin
        if (go_in === 1'b1) begin
            #DLY;
            tx_out = 1'b0;
            tx_neg_out = good_start_in;
            @(posedge ref_clk_in) #DLY;
            tx_out = 1'b1;
            tx_neg_out = 1'b0;
            repeat (len_in) begin
                @(posedge ref_clk_in) #DLY;
                tx_out = !tx_out;
                tx_neg_out = good_start_in & !tx_out;
            end
        end else begin
            #DLY;
            tx_neg_out = 1'b0;
            tx_out = !tx_out;
        end
    end
endmodule // cbt_station_model

// ### cbt_ctrl_chk.sv
`timescale 1ns/1ns
module cbt_ctrl_chk (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic coax_sense_in,
    input wire logic coax_squelch_in,
    input wire logic coax_collide_in,
    input wire logic coax_tx_permit,
    input wire logic station_rx_oe_out,
    input wire logic collision_pair_out,
    input wire logic collision_pair_oe_out,
    input wire logic coax_drive_out,
    input wire logic carrier_present_out,
    input wire logic carrier_present_oe_out,
    input wire logic jabbed_out,
    input wire logic cable_lost_out
);
    import cbt_pkg::*;
    logic [3:0] sq_age_ff;
    logic [3:0] hi_run_ff;
    logic [3:0] nxt_sq_age;
    logic [3:0] nxt_hi_run;
    // Saturating, so four bits suffice
    always_comb begin
        nxt_sq_age = (sq_age_ff == 4'hF) ? sq_age_ff : sq_age_ff + 4'h1;
        if (coax_squelch_in) nxt_sq_age = 4'h0;
        nxt_hi_run = (hi_run_ff == 4'hF) ? hi_run_ff : hi_run_ff + 4'h1;
        if (!(collision_pair_oe_out && collision_pair_out)) nxt_hi_run = 4'h0;
    end
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sq_age_ff <= 4'hF;
            hi_run_ff <= 4'h0;
        end else begin
            sq_age_ff <= nxt_sq_age;
            hi_run_ff <= nxt_hi_run;
        end
    end
    // ------
    // Checks
    // ------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_rx_wake: assert property ($rose(carrier_present_oe_out) |-> sq_age_ff < 4'h4)
        else $error("receiver opened without squelch level");
    a_rx_off: assert property (coax_sense_in [*8] |=> !carrier_present_oe_out)
        else $error("receiver stayed on through long high");
    a_rx_rearm: assert property ($fell(carrier_present_oe_out) |=> !carrier_present_oe_out [*8])
        else $error("receiver rearmed too soon");
    a_col_onset: assert property ((coax_collide_in && !cable_lost_out) [*8] |-> collision_pair_oe_out)
        else $error("collision not reported");
    a_col_low_start: assert property ($rose(collision_pair_oe_out) |-> !collision_pair_out)
        else $error("collision began high");
    a_col_high_end: assert property ($fell(collision_pair_oe_out) && !cable_lost_out |-> hi_run_ff >= COL_IDLE_CYC)
        else $error("collision ended without high idle");
    a_jab_quiet: assert property (jabbed_out |-> !coax_drive_out)
        else $error("cable driven while jabbed");
    a_permit_off: assert property (!coax_tx_permit [*4] |-> !coax_drive_out)
        else $error("cable driven without permission");
    a_lost_hiz: assert property (cable_lost_out |-> !station_rx_oe_out && !collision_pair_oe_out)
        else $error("station driver on while cable lost");
    a_carrier_sink: assert property (!carrier_present_out)
        else $error("carrier data not low");
    c_rx_on: cover property ($rose(carrier_present_oe_out));
    c_col: cover property ($rose(collision_pair_oe_out));
    c_jab: cover property ($rose(jabbed_out));
    c_lost: cover property ($rose(cable_lost_out));
endmodule // cbt_ctrl_chk

bind cbt_ctrl cbt_ctrl_chk i_cbt_ctrl_chk (
    .ref_clk_in, .rst_in, .coax_sense_in, .coax_squelch_in, .coax_collide_in,
    .coax_tx_permit, .station_rx_oe_out, .collision_pair_out, .collision_pair_oe_out,
    .coax_drive_out, .carrier_present_out, .carrier_present_oe_out, .jabbed_out,
    .cable_lost_out);

// ### cbt_ctrl_bench.sv
`timescale 1ns/1ns
module cbt_ctrl_bench;
    import cbt_pkg::*;
    localparam int JAB_T = 50;
    localparam int DISC_T = 40;
    localparam int DLY = 5;
    logic        ref_clk_in, rst_in, coax_sense_in, coax_squelch_in, coax_collide_in;
    logic        coax_open_in, heartbeat_allow, coax_tx_permit, go, good_start, tx, tx_neg;
    logic        station_rx_out, station_rx_oe_out, collision_pair_out, collision_pair_oe_out;
    logic        coax_drive_out, carrier_present_out, carrier_present_oe_out, jabbed_out;
    logic        cable_lost_out, rx_mode;
    logic [7:0]  len;
    logic [15:0] lfsr;
    int          n_errors, samples_checked, cycles, e;
    int          col_n, col_first, drv_n, jab_n, crs_n, crs_first, tog, lost_n;

    cbt_ctrl #(.JAB_CYCLES(JAB_T), .DISC_CYCLES(DISC_T)) i_cbt_ctrl (
        .ref_clk_in, .rst_in, .coax_sense_in, .coax_squelch_in, .coax_collide_in,
        .coax_open_in, .station_tx_in(tx), .station_tx_neg_in(tx_neg), .heartbeat_allow,
        .coax_tx_permit, .station_rx_out, .station_rx_oe_out, .collision_pair_out,
        .collision_pair_oe_out, .coax_drive_out, .carrier_present_out,
        .carrier_present_oe_out, .jabbed_out, .cable_lost_out);
    cbt_station_model #(.DLY(DLY)) i_cbt_station_model (
        .ref_clk_in, .go_in(go), .good_start_in(good_start), .len_in(len),
        .tx_out(tx), .tx_neg_out(tx_neg));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Heartbeat start, counted from the first watched cycle
    function automatic int hb_at(input int n);
        return n + 4 + TX_OFF_CYC + HB_DELAY_CYC;
    endfunction
    task automatic tick;
        @(posedge ref_clk_in);
        #DLY;
    endtask
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic watch(input int n);
        logic prev;
        {col_n, drv_n, jab_n, crs_n, tog, lost_n} = '0;
        col_first = -1;
        crs_first = -1;
        for (int i = 0; i < n; i++) begin
            prev = collision_pair_out;
            tick;
            // Split-phase data never holds one level past two cycles
            if (rx_mode) coax_sense_in = lfsr[0] ^ i[0];
            if (rx_mode && i[0]) lfsr = lfsr_next(lfsr);
            if (collision_pair_oe_out === 1'b1) begin
                if (col_first < 0) col_first = i;
                col_n++;
                tog += int'(collision_pair_out !== prev);
            end
            if (carrier_present_oe_out === 1'b1 && crs_first < 0) crs_first = i;
            crs_n += int'(carrier_present_oe_out === 1'b1);
            drv_n += int'(coax_drive_out === 1'b1);
            jab_n += int'(jabbed_out === 1'b1);
            lost_n += int'(cable_lost_out === 1'b1);
        end
    endtask
    task automatic send(input logic [7:0] n, input int w);
        len = n;
        go = 1'b1;
        tick;
        go = 1'b0;
        watch(w);
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) ref_clk_in = !ref_clk_in;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test;
        end
    end

    initial begin
        {coax_squelch_in, coax_collide_in, coax_open_in, go, good_start} = '0;
        {rx_mode, len} = '0;
        {coax_sense_in, heartbeat_allow, coax_tx_permit, rst_in} = 4'hF;
        lfsr = 16'h39BC;
        repeat (2) tick;
        rst_in = 1'b0;
        repeat (2) tick;
        check(!station_rx_oe_out && !collision_pair_oe_out, "drivers up at idle");
        rx_mode = 1'b1;
        watch(20);
        check(crs_n == 0, "receiver opened on noise");
        coax_squelch_in = 1'b1;
        watch(20);
        check(crs_first >= 0 && crs_first <= 12, "receiver turn-on late");
        check(station_rx_oe_out, "receive driver asleep");
        rx_mode = 1'b0;
        coax_sense_in = 1'b1;
        watch(8);
        check(!carrier_present_oe_out, "receiver on after long high");
        rx_mode = 1'b1;
        watch(4);
        check(crs_n == 0, "receiver rearmed early");
        {rx_mode, coax_squelch_in} = 2'h0;
        coax_sense_in = 1'b1;
        watch(12);
        $display("test receive done");
        for (int k = 0; k < 4; k++) begin
            coax_tx_permit = (k != 2);
            heartbeat_allow = (k != 1);
            good_start = (k != 3);
            lfsr = lfsr_next(lfsr);
            send(8'd20 + {4'h0, lfsr[3:0]}, 100);
            e = hb_at(int'(len));
            check((drv_n > 0) == (k < 2), "cable drive gating");
            if (k < 2) begin
                check(drv_n + 1 >= len / 2 && drv_n <= len / 2 + 3, "data");
            end
            if (k == 0) check(col_first >= e - 6 && col_first <= e + 6, "heartbeat start");
            if (k == 0) check(tog >= HB_BURST_CYC / 2 && col_n <= HB_BURST_CYC + 8, "burst");
            if (k == 1) check(col_n == 0, "heartbeat not suppressed");
        end
        good_start = 1'b1;
        $display("test transmit done");
        coax_collide_in = 1'b1;
        watch(30);
        check(col_first >= 0 && col_first <= 14, "collision late");
        check(tog >= 20, "collision not toggling each cycle");
        coax_collide_in = 1'b0;
        watch(12);
        check(!collision_pair_oe_out, "collision driver stuck on");
        $display("test collision done");
        send(8'd80, 130);
        e = int'(len) - JAB_T + UNJAB_CYC + TX_OFF_CYC;
        check(jab_n >= e - 8 && jab_n <= e + 8, "jabber span");
        check(col_n > 25, "no collision while jabbed");
        check(!jabbed_out, "inhibit not released");
        check(drv_n + 4 >= JAB_T / 2 && drv_n <= JAB_T / 2 + 2, "drive past limit");
        check(!coax_drive_out, "drive not stopped");
        $display("test jabber done");
        coax_open_in = 1'b1;
        watch(DISC_T - 10);
        check(lost_n == 0, "disconnect seen early");
        coax_collide_in = 1'b1;
        watch(20);
        check(lost_n > 0 && !collision_pair_oe_out, "drivers not released");
        {coax_open_in, coax_collide_in} = 2'h0;
        watch(20);
        check(!cable_lost_out, "cable lost stuck");
        $display("test disconnect done");
        finish_test;
    end
endmodule // cbt_ctrl_bench
